// File: adtsc_cfg.svh
/*
 * Register map, field positions, reset values and timing counts of the
 * converter trigger and sleep sequencer.
 * Assumes a 250 MHz system clock and a 32-bit Avalon-MM register bus.
 */
`ifndef ADTSC_CFG_SVH
`define ADTSC_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define ADTSC_OFS_CONTROL   8'h00
`define ADTSC_OFS_STATUS    8'h04
`define ADTSC_OFS_TRIGGER   8'h08
`define ADTSC_OFS_ACQUIRE   8'h0c

// ****************************************************************
// Field positions
// ****************************************************************
`define ADTSC_CTL_ON        0
`define ADTSC_CTL_GO        1
`define ADTSC_CTL_RC_CLOCK  2
`define ADTSC_CTL_REPEAT    3
`define ADTSC_CTL_IRQ_EN    4
`define ADTSC_STA_DONE      0
`define ADTSC_STA_PENDING   1
`define ADTSC_STA_POWERDN   2
`define ADTSC_STA_BUSY      3

// ****************************************************************
// Reset values
// ****************************************************************
`define ADTSC_RST_TRIG_SEL  3'h0
`define ADTSC_RST_ACQ       8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define ADTSC_CLK_NS        4
`define ADTSC_INSTR_NS      16
`define ADTSC_CONV_NS       60
`define ADTSC_INSTR_CYC     ((`ADTSC_INSTR_NS + `ADTSC_CLK_NS - 1) / `ADTSC_CLK_NS)
`define ADTSC_CONV_CYC      ((`ADTSC_CONV_NS + `ADTSC_CLK_NS - 1) / `ADTSC_CLK_NS)

`endif

// File: adtsc_pkg.sv
/*
 * Types of the converter trigger and sleep sequencer.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package adtsc_pkg;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        ADTSC_IDLE,
        ADTSC_DELAY,
        ADTSC_ACQUIRE,
        ADTSC_CONVERT
    } adtsc_state_type;

    // ****************************************************************
    // Whole module state
    // ****************************************************************
    typedef struct packed {
        adtsc_state_type state;
        logic [7:0]      count;
        logic            on;
        logic            go;
        logic            clk_rc;
        logic            repeat_mode_flag;
        logic            conversion_irq_enable;
        logic            conversion_done_flag;
        logic            pending;
        logic            powered_down;
        logic            sleep_conv;
        logic            trig_prev;
        logic [2:0]      trigger_source_field;
        logic [7:0]      acquisition_time_count;
        logic            waitrequest;
        logic [31:0]     readdata;
        logic            wake_request;
        logic            conv_done;
        logic            converting;
        logic            hold_connect;
        logic            powered;
    } adtsc_regs_type;

endpackage

`default_nettype wire

// File: adtsc_top.sv
/*
 * Start, trigger and Sleep sequencing of a 12-bit converter, with its
 * Avalon-MM register slave.
 * Assumes trigger sources and the sleep indication are on clk; the analog
 * core samples while hold_connect is high and converts while converting is high.
 */
`include "adtsc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module adtsc_top
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Avalon-MM slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output var  logic [31:0] readdata,
    output var  logic        waitrequest,
    // Processor state and trigger sources
    input  wire logic        sleep_state,
    input  wire logic [7:0]  trigger_in,
    // Converter core control
    output var  logic        converter_powered,
    output var  logic        hold_connect,
    output var  logic        converting,
    output var  logic        conversion_done,
    // System status
    output var  logic        conversion_done_flag,
    output var  logic        wake_request
);

    // ****************************************************************
    // State
    // ****************************************************************
    adtsc_pkg::adtsc_regs_type r;
    adtsc_pkg::adtsc_regs_type next_r;

    logic        trig_level;
    logic        trig_rise;
    logic        active_on;
    logic        may_run;
    logic        req;
    logic        wr_ok;
    logic [31:0] rd_word;

    // ****************************************************************
    // Register read mux
    // ****************************************************************
    function automatic logic [31:0] read_mux(
        input logic [7:0]                addr,
        input adtsc_pkg::adtsc_regs_type s
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (addr)
            `ADTSC_OFS_CONTROL:
            begin
                w[`ADTSC_CTL_ON]       = s.on;
                w[`ADTSC_CTL_GO]       = s.go;
                w[`ADTSC_CTL_RC_CLOCK] = s.clk_rc;
                w[`ADTSC_CTL_REPEAT]   = s.repeat_mode_flag;
                w[`ADTSC_CTL_IRQ_EN]   = s.conversion_irq_enable;
            end
            `ADTSC_OFS_STATUS:
            begin
                w[`ADTSC_STA_DONE]    = s.conversion_done_flag;
                w[`ADTSC_STA_PENDING] = s.pending;
                w[`ADTSC_STA_POWERDN] = s.powered_down;
                w[`ADTSC_STA_BUSY]    = (s.state != adtsc_pkg::ADTSC_IDLE);
            end
            `ADTSC_OFS_TRIGGER:
            begin
                w[2:0] = s.trigger_source_field;
            end
            `ADTSC_OFS_ACQUIRE:
            begin
                w[7:0] = s.acquisition_time_count;
            end
            default:
            begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        next_r = r;
        next_r.wake_request = 1'b0;
        next_r.conv_done    = 1'b0;

        // Field value zero selects no trigger
        trig_level = (r.trigger_source_field != 3'h0) &&
                     trigger_in[r.trigger_source_field];
        trig_rise  = trig_level && !r.trig_prev;
        next_r.trig_prev = trig_level;

        active_on = r.on && !r.powered_down;
        may_run   = !sleep_state || r.clk_rc;

        // Bus slave: one wait cycle, then answer
        req     = read || write;
        wr_ok   = write && !r.waitrequest && byteenable[0];
        rd_word = read_mux(address, r);
        if (req && r.waitrequest)
        begin
            next_r.waitrequest = 1'b0;
            next_r.readdata    = read ? rd_word : 32'h0000_0000;
        end
        else
        begin
            next_r.waitrequest = 1'b1;
        end

        if (wr_ok)
        begin
            case (address)
                `ADTSC_OFS_CONTROL:
                begin
                    next_r.on                    = writedata[`ADTSC_CTL_ON];
                    next_r.go                    = writedata[`ADTSC_CTL_GO];
                    next_r.clk_rc                = writedata[`ADTSC_CTL_RC_CLOCK];
                    next_r.repeat_mode_flag      = writedata[`ADTSC_CTL_REPEAT];
                    next_r.conversion_irq_enable = writedata[`ADTSC_CTL_IRQ_EN];
                    next_r.powered_down          = 1'b0;
                    if (!writedata[`ADTSC_CTL_ON])
                    begin
                        next_r.pending = 1'b0;
                    end
                end
                `ADTSC_OFS_STATUS:
                begin
                    if (writedata[`ADTSC_STA_DONE])
                    begin
                        next_r.conversion_done_flag = 1'b0;
                    end
                end
                `ADTSC_OFS_TRIGGER:
                begin
                    next_r.trigger_source_field = writedata[2:0];
                end
                `ADTSC_OFS_ACQUIRE:
                begin
                    next_r.acquisition_time_count = writedata[7:0];
                end
                default:
                begin
                    next_r.trig_prev = trig_level;
                end
            endcase
        end

        // Hardware triggers
        if (trig_rise && active_on)
        begin
            if (sleep_state && !r.clk_rc)
            begin
                next_r.pending = 1'b1;
            end
            else
            begin
                next_r.go = 1'b1;
            end
        end
        if (r.pending && !sleep_state && active_on)
        begin
            next_r.go = 1'b1;
        end

        // Sequencer
        case (r.state)
            adtsc_pkg::ADTSC_IDLE:
            begin
                if (r.go && active_on && may_run)
                begin
                    next_r.pending    = 1'b0;
                    next_r.sleep_conv = sleep_state;
                    if (r.clk_rc)
                    begin
                        next_r.state = adtsc_pkg::ADTSC_DELAY;
                        next_r.count = 8'(`ADTSC_INSTR_CYC - 1);
                    end
                    else
                    begin
                        next_r.state        = adtsc_pkg::ADTSC_ACQUIRE;
                        next_r.count        = r.acquisition_time_count;
                        next_r.hold_connect = 1'b1;
                    end
                end
            end
            adtsc_pkg::ADTSC_DELAY:
            begin
                if (r.count == 8'h00)
                begin
                    next_r.state        = adtsc_pkg::ADTSC_ACQUIRE;
                    next_r.count        = r.acquisition_time_count;
                    next_r.hold_connect = 1'b1;
                end
                else
                begin
                    next_r.count = r.count - 8'h01;
                end
            end
            adtsc_pkg::ADTSC_ACQUIRE:
            begin
                // Hold capacitor keeps its charge: only connected, never discharged
                if (r.count == 8'h00)
                begin
                    next_r.state        = adtsc_pkg::ADTSC_CONVERT;
                    next_r.count        = 8'(`ADTSC_CONV_CYC - 1);
                    next_r.hold_connect = 1'b0;
                    next_r.converting   = 1'b1;
                end
                else
                begin
                    next_r.count = r.count - 8'h01;
                end
            end
            adtsc_pkg::ADTSC_CONVERT:
            begin
                if (may_run)
                begin
                    if (r.count == 8'h00)
                    begin
                        next_r.state                = adtsc_pkg::ADTSC_IDLE;
                        next_r.converting           = 1'b0;
                        next_r.conv_done            = 1'b1;
                        next_r.conversion_done_flag = 1'b1;
                        if (!r.repeat_mode_flag)
                        begin
                            next_r.go = 1'b0;
                        end
                        if (sleep_state && r.conversion_irq_enable)
                        begin
                            next_r.wake_request = 1'b1;
                        end
                        if (r.sleep_conv && !r.conversion_irq_enable)
                        begin
                            next_r.powered_down = 1'b1;
                            next_r.go           = 1'b0;
                        end
                    end
                    else
                    begin
                        next_r.count = r.count - 8'h01;
                    end
                end
            end
            default:
            begin
                next_r.state = adtsc_pkg::ADTSC_IDLE;
            end
        endcase

        // Abort when start bit cleared or converter switched off
        if (r.state != adtsc_pkg::ADTSC_IDLE && !next_r.conv_done &&
            (!next_r.go || !next_r.on))
        begin
            next_r.state        = adtsc_pkg::ADTSC_IDLE;
            next_r.converting   = 1'b0;
            next_r.hold_connect = 1'b0;
        end

        next_r.powered = next_r.on && !next_r.powered_down;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r                        <= '0;
            r.state                  <= adtsc_pkg::ADTSC_IDLE;
            r.trigger_source_field   <= `ADTSC_RST_TRIG_SEL;
            r.acquisition_time_count <= `ADTSC_RST_ACQ;
            r.waitrequest            <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign readdata             = r.readdata;
    assign waitrequest          = r.waitrequest;
    assign converter_powered    = r.powered;
    assign hold_connect         = r.hold_connect;
    assign converting           = r.converting;
    assign conversion_done      = r.conv_done;
    assign conversion_done_flag = r.conversion_done_flag;
    assign wake_request         = r.wake_request;

endmodule // adtsc_top

`default_nettype wire

// File: adtsc_checker.sv
/*
 * Port checker of the converter trigger and sleep sequencer.
 * Assumes it is bound to adtsc_top, one clock, reset low.
 */
`timescale 1ns/1ns
`default_nettype none

module adtsc_checker
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Avalon-MM slave
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Processor state and triggers
    input wire logic        sleep_state,
    input wire logic [7:0]  trigger_in,
    // Converter core and status
    input wire logic        converter_powered,
    input wire logic        hold_connect,
    input wire logic        converting,
    input wire logic        conversion_done,
    input wire logic        conversion_done_flag,
    input wire logic        wake_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    chk_bus_release: assert property (!waitrequest |=> waitrequest)
        else $error("wait low too long");
    chk_bus_idle: assert property (!(read || write) |=> waitrequest)
        else $error("answer without request");
    chk_done_flag_set: assert property (conversion_done |-> conversion_done_flag)
        else $error("done without flag");
    chk_done_pulse: assert property (conversion_done |=> !conversion_done)
        else $error("done pulse too long");
    chk_conv_span: assert property (conversion_done |-> $past(converting, 15) && $past(converting))
        else $error("conversion too short");
    chk_acq_first: assert property ($rose(converting) |-> $past(hold_connect))
        else $error("no acquisition before convert");
    chk_wake_cause: assert property (wake_request |-> conversion_done && $past(sleep_state))
        else $error("stray wake request");
    chk_off_quiet: assert property (!converter_powered |-> !hold_connect && !converting)
        else $error("activity while off");

    cover property (wake_request);
    cover property ($fell(converter_powered));
    cover property (conversion_done ##1 hold_connect);
endmodule // adtsc_checker

bind adtsc_top adtsc_checker adtsc_checker_i (.clk, .rstn, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .sleep_state, .trigger_in,
    .converter_powered, .hold_connect, .converting, .conversion_done,
    .conversion_done_flag, .wake_request);

`default_nettype wire

// File: adtsc_trig_model.sv
/*
 * On-chip trigger sources feeding the sequencer.
 * Assumes the bench pulses fire for one cycle per wanted edge.
 */
`timescale 1ns/1ns
`default_nettype none

module adtsc_trig_model
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Bench command
    input  wire logic [7:0] fire,
    // Trigger levels
    output var  logic [7:0] trigger_in
);
    logic [7:0] fired;

    // Two-cycle high level, no regard to converter timing
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fired      <= 8'h00;
            trigger_in <= 8'h00;
        end
        else
        begin
            fired      <= fire;
            trigger_in <= fire | fired;
        end
    end
endmodule // adtsc_trig_model

`default_nettype wire

// File: tb_adc_trigger_sleep_control.sv
/*
 * Self-checking bench of the converter trigger and sleep sequencer.
 * Assumes adtsc_top, adtsc_trig_model and the bound checker.
 */
`include "adtsc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_adc_trigger_sleep_control;
    logic        clk, rstn, read, write, sleep_state, waitrequest;
    logic [7:0]  address, fire, trigger_in;
    logic [31:0] writedata, readdata, q;
    logic [3:0]  byteenable;
    logic        converter_powered, hold_connect, converting;
    logic        conversion_done, conversion_done_flag, wake_request;
    int          fails, n_tests, cyc, n_hold, n_conv, n_done, n_wake, t_done, t_plain;
    localparam logic [7:0]  ctl = `ADTSC_OFS_CONTROL;
    localparam logic [7:0]  sta = `ADTSC_OFS_STATUS;
    localparam logic [7:0]  trg = `ADTSC_OFS_TRIGGER;
    localparam logic [31:0] c_on = 32'h1 << `ADTSC_CTL_ON;
    localparam logic [31:0] c_go = 32'h1 << `ADTSC_CTL_GO;
    localparam logic [31:0] c_rc = 32'h1 << `ADTSC_CTL_RC_CLOCK;
    localparam logic [31:0] c_ie = 32'h1 << `ADTSC_CTL_IRQ_EN;
    localparam logic [31:0] s_dn = 32'h1 << `ADTSC_STA_DONE;

    adtsc_top adtsc_top_i (.clk, .rstn, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .sleep_state, .trigger_in, .converter_powered,
        .hold_connect, .converting, .conversion_done, .conversion_done_flag, .wake_request);
    adtsc_trig_model adtsc_trig_model_i (.clk, .rstn, .fire, .trigger_in);

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ****************************
    // Monitor and timeout
    // ****************************
    always @(posedge clk)
    begin
        cyc    <= cyc + 1;
        n_hold <= n_hold + int'(hold_connect);
        n_conv <= n_conv + int'(converting);
        n_done <= n_done + int'(conversion_done);
        n_wake <= n_wake + int'(wake_request);
        if (conversion_done === 1'b1) t_done <= cyc;
        if (cyc == 20000)
        begin
            fails++;
            give_verdict;
        end
    end

    // ****************************
    // Shared tasks
    // ****************************
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        address <= a; writedata <= d; write <= wr; read <= !wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        read <= 1'b0; write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    task automatic wait_done(input int n);
        while (n_done < n) @(posedge clk);
    endtask

    task automatic pulse(input logic [7:0] m);
        fire <= m;
        @(posedge clk);
        fire <= 8'h00;
    endtask

    // ****************************
    // Scenarios
    // ****************************
    task t_reset;
        rd(ctl, 32'h0);
        rd(sta, 32'h0);
        rd(trg, `ADTSC_RST_TRIG_SEL);
        rd(`ADTSC_OFS_ACQUIRE, `ADTSC_RST_ACQ);
        xfer(1'b1, 8'h10, 32'hff);
        rd(8'h10, 32'h0);
        byteenable <= 4'he;
        xfer(1'b1, ctl, c_on);
        byteenable <= 4'hf;
        rd(ctl, 32'h0);
    endtask

    task automatic t_soft;
        int h, c, d, t0;
        xfer(1'b1, `ADTSC_OFS_ACQUIRE, 32'h3);
        xfer(1'b1, ctl, c_on);
        h = n_hold; c = n_conv; d = n_done; t0 = cyc;
        xfer(1'b1, ctl, c_on | c_go);
        wait_done(d + 1);
        t_plain = t_done - t0;
        chk(n_hold - h, 32'h4);
        chk(n_conv - c, `ADTSC_CONV_CYC);
        rd(ctl, c_on);
        rd(sta, s_dn);
        chk(conversion_done_flag, 32'h1);
        xfer(1'b1, sta, s_dn);
        rd(sta, 32'h0);
        chk(conversion_done_flag, 32'h0);
    endtask

    task automatic t_trig;
        int d;
        d = n_done;
        xfer(1'b1, trg, 32'h3);
        pulse(8'h20);
        repeat (40) @(posedge clk);
        chk(n_done - d, 32'h0);
        for (int n = 1; n < 8; n++)
        begin
            xfer(1'b1, trg, n);
            pulse(8'h1 << n);
            wait_done(d + n);
            rd(ctl, c_on);
        end
        xfer(1'b1, trg, 32'h0);
    endtask

    task automatic t_repeat;
        int d;
        d = n_done;
        xfer(1'b1, ctl, c_on | c_go | (32'h1 << `ADTSC_CTL_REPEAT));
        wait_done(d + 2);
        rd(ctl, c_on | c_go | (32'h1 << `ADTSC_CTL_REPEAT));
        xfer(1'b1, ctl, c_on);
        xfer(1'b1, sta, s_dn);
    endtask

    task automatic t_sleep_rc;
        int d, w, t0;
        xfer(1'b1, ctl, c_on | c_rc | c_ie);
        d = n_done; t0 = cyc;
        xfer(1'b1, ctl, c_on | c_rc | c_ie | c_go);
        wait_done(d + 1);
        chk(t_done - t0 - t_plain, `ADTSC_INSTR_CYC);
        sleep_state <= 1'b1;
        w = n_wake; d = n_done;
        xfer(1'b1, trg, 32'h2);
        pulse(8'h04);
        wait_done(d + 1);
        chk(n_wake - w, 32'h1);
        rd(sta, s_dn);
        xfer(1'b1, sta, s_dn);
        xfer(1'b1, trg, 32'h0);
    endtask

    task automatic t_sleep_off;
        int d, w;
        xfer(1'b1, ctl, c_on | c_rc);
        d = n_done;
        w = n_wake;
        xfer(1'b1, ctl, c_on | c_rc | c_go);
        wait_done(d + 1);
        repeat (2) @(posedge clk);
        chk(converter_powered, 32'h0);
        chk(n_wake - w, 32'h0);
        rd(ctl, c_on | c_rc);
        rd(sta, s_dn | (32'h1 << `ADTSC_STA_POWERDN));
        sleep_state <= 1'b0;
        xfer(1'b1, ctl, c_on);
        xfer(1'b1, sta, s_dn);
        chk(converter_powered, 32'h1);
    endtask

    task automatic t_pending;
        int d, h;
        xfer(1'b1, trg, 32'h5);
        sleep_state <= 1'b1;
        d = n_done; h = n_hold;
        pulse(8'h20);
        repeat (6) @(posedge clk);
        pulse(8'h20);
        repeat (30) @(posedge clk);
        chk(n_hold - h, 32'h0);
        rd(sta, 32'h1 << `ADTSC_STA_PENDING);
        sleep_state <= 1'b0;
        wait_done(d + 1);
        repeat (40) @(posedge clk);
        chk(n_done - d, 32'h1);
        rd(sta, s_dn);
    endtask

    initial
    begin
        rstn = 1'b0; read = 1'b0; write = 1'b0; address = 8'h00; writedata = 32'h0;
        byteenable = 4'hf; sleep_state = 1'b0; fire = 8'h00;
        fails = 0; n_tests = 0; cyc = 0; n_hold = 0; n_conv = 0; n_done = 0; n_wake = 0;
        t_done = 0; t_plain = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset;
        t_soft;
        t_trig;
        t_repeat;
        t_sleep_rc;
        t_sleep_off;
        t_pending;
        give_verdict;
    end
endmodule // tb_adc_trigger_sleep_control

`default_nettype wire
